// ===== dsl_pkg.sv
// constants and carrier types for the dac serial load port
package dsl_pkg;

  // word layout
  localparam int WORD_W = 16;
  localparam int CMD_W = 4;
  localparam int DATA_W = 12;
  localparam int CMD_LSB = 12;
  localparam int CMD_MSB = 15;
  localparam int DATA_LSB = 0;
  localparam int DATA_MSB = 11;

  // active edge counter
  localparam int CNT_W = 5;
  localparam logic [CNT_W-1:0] CNT_RST = 5'h00;
  localparam logic [CNT_W-1:0] CNT_FIRST = 5'h01;
  localparam logic [CNT_W-1:0] CNT_ONE = 5'h01;
  localparam logic [CNT_W-1:0] CNT_LAST = 5'h10;

  // reset values
  localparam logic [WORD_W-1:0] WORD_RST = 16'h0000;
  localparam logic [DATA_W-1:0] DAC_RST = 12'h000;
  localparam logic EDGE_RISE_RST = 1'b0;
  localparam logic SDO_RST = 1'b0;

  // command codes in the top nibble
  localparam logic [CMD_W-1:0] CMD_NOP = 4'h0;
  localparam logic [CMD_W-1:0] CMD_LOAD = 4'h1;
  localparam logic [CMD_W-1:0] CMD_READBACK = 4'h2;
  localparam logic [CMD_W-1:0] CMD_EDGE_FALL = 4'h9;
  localparam logic [CMD_W-1:0] CMD_EDGE_RISE = 4'hA;

  // serial clock limits and system clock
  localparam int SCLK_MAX_MHZ = 50;
  localparam int SCLK_MIN_PERIOD_NS = 20;
  localparam int SYS_CLK_MHZ = 10;
  localparam int SYS_PERIOD_NS = 1000 / SYS_CLK_MHZ;

  typedef enum logic [2:0]
  {
    DSL_S_IDLE = 3'b001,
    DSL_S_OPEN = 3'b010,
    DSL_S_TAKEN = 3'b100
  } dsl_state_t;

  typedef struct packed
  {
    logic [WORD_W-1:0] shreg;
    logic [CNT_W-1:0] cnt;
    logic seen_tog;
    logic [DATA_W-1:0] dac;
    logic [WORD_W-1:0] word;
    logic word_tog;
    logic edge_pend;
  } dsl_link_t;

  typedef struct packed
  {
    logic edge_rise;
    logic end_tog;
  } dsl_frame_t;

  typedef struct packed
  {
    logic tog_s1;
    logic tog_s2;
    logic tog_seen;
    logic frm_s1;
    logic frm_s2;
    logic edge_s1;
    logic edge_s2;
    logic [WORD_W-1:0] word;
    logic [DATA_W-1:0] dac;
    logic strobe;
    dsl_state_t state;
  } dsl_sys_t;

  typedef struct packed
  {
    logic serial_data_out;
  } dsl_out_t;

endpackage : dsl_pkg

// ===== dsl_out_stage.sv
// serial data output stage clocked on the edge opposite the sampling edge
`timescale 1ns/1ns
module dsl_out_stage
(
  input wire logic opp_clk_i,
  input wire logic rst_b_i,
  input wire logic frame_sel_b_i,
  input wire logic bit_i,
  output logic serial_data_out_o
);
  import dsl_pkg::*;

  dsl_out_t st_r;
  dsl_out_t st_nxt;

  always_comb
  begin
    st_nxt = st_r;
    // only a live frame moves the output
    if (!frame_sel_b_i)
    begin
      st_nxt.serial_data_out = bit_i;
    end
  end

  always_ff @(posedge opp_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      st_r <= '{serial_data_out: SDO_RST};
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign serial_data_out_o = st_r.serial_data_out;

endmodule : dsl_out_stage

// ===== dsl_port.sv
// serial load port: shift register, edge counter, word latch and system handoff
`timescale 1ns/1ns
module dsl_port
(
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic sclk_i,
  input wire logic frame_sel_b_i,
  input wire logic serial_data_in_i,
  output logic serial_data_out_o,
  output logic [dsl_pkg::WORD_W-1:0] word_o,
  output logic word_strobe_o,
  output logic [dsl_pkg::DATA_W-1:0] dac_o,
  output logic edge_rise_o,
  output logic frame_open_o,
  output logic word_pending_o
);
  import dsl_pkg::*;

  function automatic logic [CMD_W-1:0] cmd_of(input logic [WORD_W-1:0] w);
    cmd_of = w[CMD_MSB:CMD_LSB];
  endfunction : cmd_of

  function automatic logic [DATA_W-1:0] data_of(input logic [WORD_W-1:0] w);
    data_of = w[DATA_MSB:DATA_LSB];
  endfunction : data_of

  // a toggle that differs from its seen copy marks a new event
  function automatic logic tog_moved(input logic now_v, input logic seen_v);
    tog_moved = (now_v != seen_v);
  endfunction : tog_moved

  // command decode at the latch edge
  function automatic dsl_link_t apply_cmd(input dsl_link_t cur, input logic [WORD_W-1:0] w);
    apply_cmd = cur;
    case (cmd_of(w))
      CMD_NOP:
      begin
        // no operation, word is only reported
        apply_cmd.dac = cur.dac;
      end

      CMD_LOAD:
      begin
        apply_cmd.dac = data_of(w);
      end

      CMD_READBACK:
      begin
        // four zero bits, then dac contents msb first, leave from the next opposite edge
        apply_cmd.shreg = {{CMD_W{1'b0}}, cur.dac};
      end

      CMD_EDGE_RISE:
      begin
        apply_cmd.edge_pend = 1'b1;
      end

      CMD_EDGE_FALL:
      begin
        apply_cmd.edge_pend = 1'b0;
      end

      default:
      begin
        apply_cmd.dac = cur.dac;
      end
    endcase
  endfunction : apply_cmd

  dsl_link_t lk_r;
  dsl_link_t lk_nxt;
  dsl_frame_t fr_r;
  dsl_frame_t fr_nxt;
  dsl_sys_t sy_r;
  dsl_sys_t sy_nxt;

  logic act_clk;
  logic opp_clk;
  logic frame_open;
  logic new_frame;
  logic [WORD_W-1:0] shifted;
  logic [CNT_W-1:0] cnt_step;
  logic take_word;
  logic below_last;
  logic got_word;

  // sampling clock follows the selected polarity
  // polarity only moves at frame close, when link updates are gated off
  // a polarity switch may make one sampling edge; frame select is high then, so it changes nothing
  assign act_clk = fr_r.edge_rise ? sclk_i : ~sclk_i;
  assign opp_clk = ~act_clk;

  // buffers live only while frame select is low
  assign frame_open = ~frame_sel_b_i;

  // a frame-close toggle not yet seen marks the first edge of a new frame
  assign new_frame = tog_moved(lk_r.seen_tog, fr_r.end_tog);
  assign shifted = {lk_r.shreg[WORD_W-2:0], serial_data_in_i};

  // count saturates at sixteen so a long frame latches once
  assign below_last = (lk_r.cnt != CNT_LAST);

  always_comb
  begin
    cnt_step = lk_r.cnt;
    if (new_frame)
    begin
      cnt_step = CNT_FIRST;
    end
    else if (below_last)
    begin
      cnt_step = lk_r.cnt + CNT_ONE;
    end
  end

  // word is taken at most once, on the sixteenth edge of the frame
  assign take_word = frame_open && (cnt_step == CNT_LAST) && (new_frame || below_last);

  // link domain: active serial clock edge
  always_comb
  begin
    lk_nxt = lk_r;
    if (frame_open)
    begin
      lk_nxt.shreg = shifted;
      lk_nxt.cnt = cnt_step;
      // first edge of a frame acknowledges the close toggle
      lk_nxt.seen_tog = fr_r.end_tog;
      // sixteenth edge: latch the word and act on its command
      if (take_word)
      begin
        lk_nxt.word = shifted;
        lk_nxt.word_tog = ~lk_r.word_tog;
        lk_nxt = apply_cmd(lk_nxt, shifted);
      end
    end
  end

  always_ff @(posedge act_clk or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      lk_r <= '{
        shreg: WORD_RST,
        cnt: CNT_RST,
        seen_tog: 1'b0,
        dac: DAC_RST,
        word: WORD_RST,
        word_tog: 1'b0,
        edge_pend: EDGE_RISE_RST
      };
    end
    else
    begin
      lk_r <= lk_nxt;
    end
  end

  // frame close: apply pending polarity and toggle end_tog so the next frame restarts the count
  // link state is idle here since its updates are gated by the frame
  always_comb
  begin
    fr_nxt = fr_r;
    fr_nxt.edge_rise = lk_r.edge_pend;
    // toggle tells the link domain that the frame closed
    fr_nxt.end_tog = ~fr_r.end_tog;
  end

  always_ff @(posedge frame_sel_b_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      fr_r <= '{
        edge_rise: EDGE_RISE_RST,
        end_tog: 1'b0
      };
    end
    else
    begin
      fr_r <= fr_nxt;
    end
  end

  // cascade output follows the msb of the shift register
  dsl_out_stage u_out
  (
    .opp_clk_i(opp_clk),
    .rst_b_i(rst_b_i),
    .frame_sel_b_i(frame_sel_b_i),
    .bit_i(lk_r.shreg[WORD_W-1]),
    .serial_data_out_o(serial_data_out_o)
  );

  // system domain: synchronisers, word capture, frame monitor
  assign got_word = tog_moved(sy_r.tog_s2, sy_r.tog_seen);

  always_comb
  begin
    sy_nxt = sy_r;
    // word toggle crossing
    sy_nxt.tog_s1 = lk_r.word_tog;
    sy_nxt.tog_s2 = sy_r.tog_s1;

    // frame select pin
    sy_nxt.frm_s1 = frame_open;
    sy_nxt.frm_s2 = sy_r.frm_s1;

    // sampling polarity
    sy_nxt.edge_s1 = fr_r.edge_rise;
    sy_nxt.edge_s2 = sy_r.edge_s1;

    sy_nxt.strobe = 1'b0;
    // link word and dac are stable long before the toggle lands here
    if (got_word)
    begin
      sy_nxt.tog_seen = sy_r.tog_s2;
      sy_nxt.word = lk_r.word;
      sy_nxt.dac = lk_r.dac;
      sy_nxt.strobe = 1'b1;
    end
    case (sy_r.state)
      DSL_S_IDLE:
      begin
        if (sy_r.frm_s2)
        begin
          sy_nxt.state = DSL_S_OPEN;
        end
      end

      DSL_S_OPEN:
      begin
        if (got_word)
        begin
          sy_nxt.state = DSL_S_TAKEN;
        end
        else if (!sy_r.frm_s2)
        begin
          sy_nxt.state = DSL_S_IDLE;
        end
      end

      DSL_S_TAKEN:
      begin
        if (!sy_r.frm_s2)
        begin
          sy_nxt.state = DSL_S_IDLE;
        end
      end
      default:
      begin
        sy_nxt.state = DSL_S_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      sy_r <= '{
        tog_s1: 1'b0,
        tog_s2: 1'b0,
        tog_seen: 1'b0,
        frm_s1: 1'b0,
        frm_s2: 1'b0,
        edge_s1: EDGE_RISE_RST,
        edge_s2: EDGE_RISE_RST,
        word: WORD_RST,
        dac: DAC_RST,
        strobe: 1'b0,
        state: DSL_S_IDLE
      };
    end
    else
    begin
      sy_r <= sy_nxt;
    end
  end

  assign word_o = sy_r.word;
  assign word_strobe_o = sy_r.strobe;
  assign dac_o = sy_r.dac;
  assign edge_rise_o = sy_r.edge_s2;
  assign frame_open_o = sy_r.frm_s2;
  // open frame that has not yet delivered its word
  assign word_pending_o = (sy_r.state == DSL_S_OPEN);

endmodule : dsl_port

// ===== dsl_sva.sv
// assertions on the serial load port top ports
`timescale 1ns/1ns
module dsl_sva
  import dsl_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic frame_sel_b_i,
  input wire logic serial_data_out_o,
  input wire logic [WORD_W-1:0] word_o,
  input wire logic word_strobe_o,
  input wire logic [DATA_W-1:0] dac_o,
  input wire logic edge_rise_o,
  input wire logic frame_open_o,
  input wire logic word_pending_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  a_fall_reset: assert property ($rose(rst_b_i) |-> !edge_rise_o)
    else $error("edge not falling after reset");
  a_edge_closed: assert property ($changed(edge_rise_o) |-> !frame_open_o)
    else $error("edge changed in open frame");
  a_rise_cmd: assert property (word_strobe_o && word_o[CMD_MSB:CMD_LSB] == CMD_EDGE_RISE |-> ##[0:4] edge_rise_o)
    else $error("rising edge not applied");
  a_word_strobe: assert property ($changed(word_o) |-> word_strobe_o)
    else $error("word changed without strobe");
  a_dac_strobe: assert property ($changed(dac_o) |-> word_strobe_o)
    else $error("dac changed without strobe");
  a_load_dac: assert property (word_strobe_o && word_o[CMD_MSB:CMD_LSB] == CMD_LOAD |-> dac_o == word_o[DATA_MSB:0])
    else $error("dac not loaded");
  a_open_sync: assert property ($fell(frame_sel_b_i) |-> ##[1:3] frame_open_o)
    else $error("frame open missing");
  a_sdo_framed: assert property ($changed(serial_data_out_o) |-> !frame_sel_b_i || !$past(frame_sel_b_i))
    else $error("output moved outside frame");
  a_pending_open: assert property (word_pending_o |-> $past(frame_open_o))
    else $error("pending without open frame");
endmodule : dsl_sva

bind dsl_port dsl_sva chk (.clk_i(clk_i), .rst_b_i(rst_b_i), .frame_sel_b_i(frame_sel_b_i),
  .serial_data_out_o(serial_data_out_o), .word_o(word_o), .word_strobe_o(word_strobe_o), .dac_o(dac_o),
  .edge_rise_o(edge_rise_o), .frame_open_o(frame_open_o), .word_pending_o(word_pending_o));

// ===== dsl_host.sv
// serial controller model for the load port link
`timescale 1ns/1ns
module dsl_host
(
  input wire logic sdo_i,
  output logic sclk_o,
  output logic frame_sel_b_o,
  output logic sdi_o
);
  initial
  begin
    sclk_o = 1'b0;
    frame_sel_b_o = 1'b1;
    sdi_o = 1'b0;
  end
  // n bits msb first, 15 ns per bit, the bench link clock
  task automatic xfer(input logic [15:0] w, input int n, input logic r, output logic [15:0] rd);
    rd = 16'h0000;
    if (sclk_o !== r)
    begin
      #20 sclk_o = r; // idle level suits the active edge
    end
    #20 frame_sel_b_o = 1'b0;
    for (int i = 0; i < n; i++)
    begin
      sdi_o = w[15-i];
      #5 sclk_o = ~r; // opposite edge first
      #7 rd = {rd[14:0], sdo_i};
      sclk_o = r;
      #3;
    end
    sdi_o = ~sdi_o;
    frame_sel_b_o = 1'b1;
  endtask : xfer
endmodule : dsl_host

// ===== dsl_tb.sv
// testbench for the dac serial load port
`timescale 1ns/1ns
`define CHK(a, b) n_tests++; if ((a) !== (b)) begin num_errors++; $display("MISMATCH %0t got %h", $time, a); end
module testbench;
  import dsl_pkg::*;
  logic clk_i, rst_b_i, sclk, fsb, sdi, serial_data_out, strobe, er;
  logic [WORD_W-1:0] word, rd;
  logic [DATA_W-1:0] dac;
  int num_errors = 0;
  int n_tests = 0;
  dsl_host host (.sdo_i(serial_data_out), .sclk_o(sclk), .frame_sel_b_o(fsb), .sdi_o(sdi));
  dsl_port uut (.clk_i(clk_i), .rst_b_i(rst_b_i), .sclk_i(sclk), .frame_sel_b_i(fsb), .serial_data_in_i(sdi),
    .serial_data_out_o(serial_data_out), .word_o(word), .word_strobe_o(strobe), .dac_o(dac), .edge_rise_o(er),
    .frame_open_o(), .word_pending_o());
  initial
  begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  task automatic results();
    $display("tests %0d errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : results
  task automatic frame(input logic [15:0] w, input logic r, input logic [15:0] exp_rd);
    int k;
    k = 0;
    host.xfer(w, 16, r, rd);
    `CHK(rd, exp_rd)
    while (strobe !== 1'b1 && k < 20)
    begin
      @(negedge clk_i);
      k++;
    end
    `CHK(k < 20, 1'b1)
    if (k >= 20)
      results();
    `CHK(word, w)
    repeat (4) @(negedge clk_i);
  endtask : frame
  task automatic t_reset();
    `CHK(er, 1'b0)
    `CHK(dac, DAC_RST)
    $display("t_reset done");
  endtask : t_reset
  task automatic t_load();
    frame({CMD_LOAD, 12'hA5C}, 1'b0, 16'h0000);
    `CHK(dac, 12'hA5C)
    frame({CMD_NOP, 12'h3C3}, 1'b0, 16'h1A5C);
    `CHK(dac, 12'hA5C)
    $display("t_load done");
  endtask : t_load
  task automatic t_short();
    host.xfer(16'hFFFF, 8, 1'b0, rd);
    repeat (10) @(negedge clk_i);
    `CHK(word, 16'h03C3)
    `CHK(rd, 16'h0003)
    frame({CMD_LOAD, 12'h123}, 1'b0, 16'hC3FF);
    $display("t_short done");
  endtask : t_short
  task automatic t_readback();
    frame({CMD_READBACK, 12'h000}, 1'b0, 16'h1123);
    frame({CMD_NOP, 12'h000}, 1'b0, 16'h0123);
    `CHK(dac, 12'h123)
    $display("t_readback done");
  endtask : t_readback
  task automatic t_rise();
    frame({CMD_EDGE_RISE, 12'h000}, 1'b0, 16'h0000);
    `CHK(er, 1'b1)
    frame({CMD_LOAD, 12'h5A6}, 1'b1, 16'hA000);
    `CHK(dac, 12'h5A6)
    frame({CMD_READBACK, 12'h000}, 1'b1, 16'h15A6);
    frame({CMD_EDGE_FALL, 12'h000}, 1'b1, 16'h05A6);
    `CHK(er, 1'b0)
    frame({CMD_LOAD, 12'h0FF}, 1'b0, 16'h9000);
    `CHK(dac, 12'h0FF)
    $display("t_rise done");
  endtask : t_rise
  initial
  begin
    rst_b_i = 1'b0;
    repeat (12) @(negedge clk_i);
    rst_b_i = 1'b1;
    @(negedge clk_i);
    t_reset();
    t_load();
    t_short();
    t_readback();
    t_rise();
    results();
  end
endmodule : testbench
